// >>> verilog/vout_margin_pkg.sv
// constants shared by the margin, slew and droop register bank
package vout_margin_pkg;
    localparam int unsigned NUM_PAGES  = 2;
    localparam int unsigned PAGE_IDX_W = 1;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned CMD_W      = 8;

    // command codes of the four paged registers
    localparam logic [CMD_W-1:0] CMD_MARGIN_HIGH = 8'h25;
    localparam logic [CMD_W-1:0] CMD_MARGIN_LOW  = 8'h26;
    localparam logic [CMD_W-1:0] CMD_SLEW        = 8'h27;
    localparam logic [CMD_W-1:0] CMD_DROOP       = 8'h28;

    // page pointer value that addresses every output at once on writes; a read of it returns page 0
    localparam logic [CMD_W-1:0] PAGE_ALL = 8'hFF;

    // write-protect settings
    localparam logic [CMD_W-1:0] WP_NONE      = 8'h00;
    localparam logic [CMD_W-1:0] WP_CTRL_ONLY = 8'h40;
    localparam logic [CMD_W-1:0] WP_CTRL_VOUT = 8'h20;

    // reset values, direct format
    localparam logic [DATA_W-1:0] RST_MARGIN_HIGH = 16'h0640;
    localparam logic [DATA_W-1:0] RST_MARGIN_LOW  = 16'h00FA;
    localparam logic [DATA_W-1:0] RST_SLEW        = 16'h0064;
    localparam logic [DATA_W-1:0] RST_DROOP       = 16'h0000;
    localparam logic [DATA_W-1:0] RST_TARGET      = 16'h0000;
    localparam logic [DATA_W-1:0] READ_ZERO       = 16'h0000;

    // droop span of 16 mV/A in 10 uV/A steps is 1600 counts
    localparam logic [DATA_W-1:0] DROOP_MAX = 16'h0640;

    // operation control target selection
    typedef enum logic [1:0] {
        OP_NOMINAL     = 2'h0,
        OP_MARGIN_LOW  = 2'h1,
        OP_MARGIN_HIGH = 2'h2
    } op_sel_t;
endpackage

// >>> verilog/margin_target_select.sv
// per-output target selection with min/max window limiting
`timescale 1ns/1ns
`default_nettype none
module margin_target_select
    import vout_margin_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic [1:0]        op_sel,
    input  wire logic [DATA_W-1:0] nominal,
    input  wire logic [DATA_W-1:0] margin_high,
    input  wire logic [DATA_W-1:0] margin_low,
    input  wire logic [DATA_W-1:0] vout_min,
    input  wire logic [DATA_W-1:0] vout_max,
    output logic      [DATA_W-1:0] target_q,
    output logic                   margin_active_q
);
    logic [DATA_W-1:0] raw;
    logic [DATA_W-1:0] target_d;

    // pick the requested target; unknown codes fall back to nominal
    always_comb begin
        case (op_sel)
            OP_MARGIN_HIGH: raw = margin_high;
            OP_MARGIN_LOW:  raw = margin_low;
            default:        raw = nominal;
        endcase
        // limit to the window; max checked first so a crossed window lands on min
        if (raw > vout_max) begin
            target_d = vout_max;
        end else begin
            target_d = raw;
        end
        if (target_d < vout_min) begin
            target_d = vout_min;
        end
    end

    // registered so the regulation loop sees a clean word
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            target_q        <= RST_TARGET;
            margin_active_q <= 1'b0;
        end else begin
            target_q        <= target_d;
            margin_active_q <= (op_sel == OP_MARGIN_HIGH) || (op_sel == OP_MARGIN_LOW);
        end
    end
endmodule
`default_nettype wire

// >>> verilog/vout_margin_slew_droop_regs.sv
// paged margin, slew-rate and droop register bank with commit staging
`timescale 1ns/1ns
`default_nettype none
// Function
// - margin-high word at 25h drives the target when margin-high is selected
// - margin-high resets to 0640h, that is 1600 mV
// - margin-low word at 26h drives the target when margin-low is selected
// - margin-low resets to 00FAh, that is 250 mV
// - slew word at 27h counts 100 uV/us steps, resets to 0064h
// - a written slew word applies only after commit; old rate holds meanwhile
// - droop word at 28h counts 10 uV/A steps, up to 16 mV/A, resets zero
// - droop changes apply only after commit, which the host must send
// - all four words are paged, two bytes, readable and writable
// - writes refused unless write protect is 00h
module vout_margin_slew_droop_regs
    import vout_margin_pkg::*;
(
    input  wire logic                              clk_sys,
    input  wire logic                              rst_n,
    input  wire logic [CMD_W-1:0]                  page,
    input  wire logic [CMD_W-1:0]                  cmd_code,
    input  wire logic                              wr_strobe,
    input  wire logic [DATA_W-1:0]                 wr_data,
    input  wire logic                              rd_strobe,
    input  wire logic [CMD_W-1:0]                  wp_setting,
    input  wire logic                              commit_settings,
    input  wire logic [NUM_PAGES-1:0][1:0]         op_sel,
    input  wire logic [NUM_PAGES-1:0][DATA_W-1:0]  vout_nominal,
    input  wire logic [NUM_PAGES-1:0][DATA_W-1:0]  vout_min,
    input  wire logic [NUM_PAGES-1:0][DATA_W-1:0]  vout_max,
    output logic      [DATA_W-1:0]                 rd_data_q,
    output logic                                   rd_valid_q,
    output logic                                   cmd_nack_q,
    output logic                                   wr_refused_q,
    output logic      [NUM_PAGES-1:0][DATA_W-1:0]  slew_applied_q,
    output logic      [NUM_PAGES-1:0][DATA_W-1:0]  droop_applied_q,
    output logic      [NUM_PAGES-1:0][DATA_W-1:0]  vout_target_q,
    output logic      [NUM_PAGES-1:0]              margin_active_q
);
    logic [NUM_PAGES-1:0][DATA_W-1:0] mh_q;
    logic [NUM_PAGES-1:0][DATA_W-1:0] ml_q;
    logic [NUM_PAGES-1:0][DATA_W-1:0] slew_pend_q;
    logic [NUM_PAGES-1:0][DATA_W-1:0] droop_pend_q;
    logic [NUM_PAGES-1:0]             pg_sel;
    logic                             page_ok;
    logic                             cmd_mapped;
    logic                             wr_allowed;
    logic [PAGE_IDX_W-1:0]            rd_page;
    logic [DATA_W-1:0]                rd_data_d;

    ////////////////////////////////////////////////////////////////////////
    // command decode

    // broadcast page writes every copy; a read of it returns page 0
    assign page_ok    = (page < CMD_W'(NUM_PAGES)) || (page == PAGE_ALL);
    assign cmd_mapped = (cmd_code == CMD_MARGIN_HIGH) || (cmd_code == CMD_MARGIN_LOW)
                     || (cmd_code == CMD_SLEW) || (cmd_code == CMD_DROOP);
    // protect gate: only the open setting lets writes in
    assign wr_allowed = (wp_setting == WP_NONE);
    assign rd_page    = (page == PAGE_ALL) ? PAGE_IDX_W'(0) : page[PAGE_IDX_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // per-page storage

    genvar p;
    generate
        for (p = 0; p < NUM_PAGES; p++) begin : g_page
            logic wr_do;
            assign pg_sel[p] = (page == CMD_W'(p)) || (page == PAGE_ALL);
            assign wr_do     = wr_strobe && cmd_mapped && page_ok && wr_allowed && pg_sel[p];

            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    mh_q[p]         <= RST_MARGIN_HIGH;
                    ml_q[p]         <= RST_MARGIN_LOW;
                    slew_pend_q[p]  <= RST_SLEW;
                    droop_pend_q[p] <= RST_DROOP;
                end else if (wr_do) begin
                    case (cmd_code)
                        CMD_MARGIN_HIGH: mh_q[p]         <= wr_data;
                        CMD_MARGIN_LOW:  ml_q[p]         <= wr_data;
                        CMD_SLEW:        slew_pend_q[p]  <= wr_data;
                        CMD_DROOP:       droop_pend_q[p] <= wr_data;
                        default:         mh_q[p]         <= mh_q[p];
                    endcase
                end
            end

            // staging: applied copies move only on commit
            // commit in the same cycle as a write takes the older word
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    slew_applied_q[p]  <= RST_SLEW;
                    droop_applied_q[p] <= RST_DROOP;
                end else if (commit_settings) begin
                    slew_applied_q[p]  <= slew_pend_q[p];
                    // droop span limit on the applied gain
                    droop_applied_q[p] <= (droop_pend_q[p] > DROOP_MAX) ? DROOP_MAX
                                                                        : droop_pend_q[p];
                end
            end

            // margin target selection and window limit
            margin_target_select u_sel (
                .clk_sys         (clk_sys),
                .rst_n           (rst_n),
                .op_sel          (op_sel[p]),
                .nominal         (vout_nominal[p]),
                .margin_high     (mh_q[p]),
                .margin_low      (ml_q[p]),
                .vout_min        (vout_min[p]),
                .vout_max        (vout_max[p]),
                .target_q        (vout_target_q[p]),
                .margin_active_q (margin_active_q[p])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // readback and status

    // read mux; unmapped codes select zero, but such reads leave the read word unchanged and flag a nack
    always_comb begin
        case (cmd_code)
            CMD_MARGIN_HIGH: rd_data_d = mh_q[rd_page];
            CMD_MARGIN_LOW:  rd_data_d = ml_q[rd_page];
            CMD_SLEW:        rd_data_d = slew_pend_q[rd_page];
            CMD_DROOP:       rd_data_d = droop_pend_q[rd_page];
            default:         rd_data_d = READ_ZERO;
        endcase
    end

    // one-cycle answers; the read word holds until the next read
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data_q    <= READ_ZERO;
            rd_valid_q   <= 1'b0;
            cmd_nack_q   <= 1'b0;
            wr_refused_q <= 1'b0;
        end else begin
            rd_valid_q   <= rd_strobe && cmd_mapped && page_ok;
            cmd_nack_q   <= (rd_strobe || wr_strobe) && !(cmd_mapped && page_ok);
            // refusal flag, a pulse per blocked write
            wr_refused_q <= wr_strobe && cmd_mapped && page_ok && !wr_allowed;
            if (rd_strobe && cmd_mapped && page_ok) begin
                rd_data_q <= (page_ok) ? rd_data_d : READ_ZERO;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_mh_reset_value: assert property ($rose(rst_n) |-> mh_q[0] == RST_MARGIN_HIGH)
        else $error("margin-high not at reset value");
    a_ml_reset_value: assert property ($rose(rst_n) |-> ml_q[0] == RST_MARGIN_LOW)
        else $error("margin-low not at reset value");
    a_slew_reset_value: assert property ($rose(rst_n) |-> slew_applied_q[0] == RST_SLEW
                                         && droop_applied_q[0] == RST_DROOP)
        else $error("slew or droop not at reset value");
    a_write_stores_word: assert property (wr_strobe && wr_allowed && page == 8'h00
                                          && cmd_code == CMD_MARGIN_LOW
                                          |=> ml_q[0] == $past(wr_data) && rd_valid_q == 1'b0
                                              || ml_q[0] == $past(wr_data))
        else $error("allowed write not stored");
    a_protect_blocks: assert property (wr_strobe && !wr_allowed && cmd_mapped && page_ok
                                       |=> $stable(mh_q) && $stable(ml_q)
                                           && $stable(slew_pend_q) && wr_refused_q)
        else $error("protected write changed a word");
    a_slew_held: assert property (!commit_settings |=> $stable(slew_applied_q))
        else $error("slew changed without commit");
    a_slew_commit: assert property (commit_settings |=> slew_applied_q[0] == $past(slew_pend_q[0]))
        else $error("commit did not apply slew");
    a_droop_commit: assert property (commit_settings && droop_pend_q[1] <= DROOP_MAX
                                     |=> droop_applied_q[1] == $past(droop_pend_q[1]))
        else $error("commit did not apply droop");
    a_droop_span: assert property (droop_applied_q[0] <= DROOP_MAX)
        else $error("applied droop beyond span");
    a_margin_high_sel: assert property (op_sel[0] == OP_MARGIN_HIGH && mh_q[0] >= vout_min[0]
                                        && mh_q[0] <= vout_max[0]
                                        |=> vout_target_q[0] == $past(mh_q[0]))
        else $error("margin-high target not applied");
    a_margin_low_sel: assert property (op_sel[0] == OP_MARGIN_LOW && ml_q[0] >= vout_min[0]
                                       && ml_q[0] <= vout_max[0]
                                       |=> vout_target_q[0] == $past(ml_q[0]) && margin_active_q[0])
        else $error("margin-low target not applied");
    a_target_window: assert property (op_sel[0] == OP_MARGIN_HIGH && vout_min[0] <= vout_max[0]
                                      |=> vout_target_q[0] <= $past(vout_max[0])
                                          && vout_target_q[0] >= $past(vout_min[0]))
        else $error("margin target outside window");
    a_read_answer: assert property (rd_strobe && page == 8'h00 && cmd_code == CMD_MARGIN_HIGH
                                    |=> rd_valid_q && rd_data_q == $past(mh_q[0]))
        else $error("read answer wrong");

    // refusal and staging checks on the paths the table does not reach
    a_nack_unmapped: assert property ((rd_strobe || wr_strobe) && !cmd_mapped
                                      |=> cmd_nack_q && !rd_valid_q && !wr_refused_q)
        else $error("unmapped command not refused");
    a_bad_page_hold: assert property (rd_strobe && !page_ok
                                      |=> cmd_nack_q && $stable(rd_data_q))
        else $error("bad page read changed the read word");
    a_droop_held: assert property (!commit_settings |=> $stable(droop_applied_q))
        else $error("droop changed without commit");
    a_droop_commit_p0: assert property (commit_settings && droop_pend_q[0] <= DROOP_MAX
                                        |=> droop_applied_q[0] == $past(droop_pend_q[0]))
        else $error("commit did not apply droop on page 0");
    a_droop_saturate: assert property (commit_settings && droop_pend_q[1] > DROOP_MAX
                                       |=> droop_applied_q[1] == DROOP_MAX)
        else $error("oversized droop not held at span");

    c_commit_slew: cover property (wr_strobe && wr_allowed && cmd_code == CMD_SLEW
                                   ##[1:8] commit_settings);
    c_refused_write: cover property (wr_strobe && wp_setting == WP_CTRL_ONLY && cmd_mapped);
    c_broadcast: cover property (wr_strobe && wr_allowed && page == PAGE_ALL && cmd_mapped);
    c_margin_clamped: cover property (op_sel[1] == OP_MARGIN_HIGH && mh_q[1] > vout_max[1]);
endmodule
`default_nettype wire

// >>> tb/host_bus_model.sv
// host model that drives the register port of the margin register bank
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
    import vout_margin_pkg::*;
(
    input  wire logic              clk_sys,
    output logic      [CMD_W-1:0]  page,
    output logic      [CMD_W-1:0]  cmd_code,
    output logic                   wr_strobe,
    output logic      [DATA_W-1:0] wr_data,
    output logic                   rd_strobe,
    output logic      [CMD_W-1:0]  wp_setting,
    output logic                   commit_settings,
    input  wire logic [DATA_W-1:0] rd_data_q,
    input  wire logic              rd_valid_q,
    input  wire logic              cmd_nack_q,
    input  wire logic              wr_refused_q
);
    // idle values at time zero; all tasks are entered just after a falling edge
    initial begin
        page = 8'h00;
        cmd_code = 8'h00;
        wr_strobe = 1'b0;
        wr_data = 16'h5a5a;
        rd_strobe = 1'b0;
        wp_setting = WP_NONE;
        commit_settings = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // one write; the one-cycle answer pulses are caught inside their cycle
    task automatic wr(input logic [7:0] pg, input logic [7:0] cmd, input logic [15:0] d,
                      input logic [7:0] wp, output logic refused, output logic nack);
        page = pg;
        cmd_code = cmd;
        wr_data = d;
        wp_setting = wp;
        wr_strobe = 1'b1;
        @(negedge clk_sys);
        // the answer pulse stands only between the taking edge and the next one
        refused = wr_refused_q;
        nack = cmd_nack_q;
        wr_strobe = 1'b0;
        wr_data = ~d;  // released word shows its inverse so a stale value cannot pass
        @(negedge clk_sys);
    endtask
    // one read; polls a few cycles so a silent device cannot hang the run
    task automatic rd(input logic [7:0] pg, input logic [7:0] cmd, output logic [15:0] d,
                      output logic ok, output logic nack, output logic tmo);
        page = pg;
        cmd_code = cmd;
        rd_strobe = 1'b1;
        tmo = 1'b1;
        // first look falls inside the cycle after the taking edge, where the pulse stands
        for (int k = 0; k < 4 && tmo; k++) begin
            @(negedge clk_sys);
            rd_strobe = 1'b0;
            ok = rd_valid_q;
            nack = cmd_nack_q;
            d = rd_data_q;
            tmo = !(ok === 1'b1 || nack === 1'b1);
        end
        @(negedge clk_sys);
    endtask
    task automatic commit();
        commit_settings = 1'b1;
        @(negedge clk_sys);
        commit_settings = 1'b0;
        @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

// >>> tb/vout_margin_slew_droop_regs_tb_top.sv
// self-checking bench for the margin, slew and droop register bank
`timescale 1ns/1ns
`default_nettype none
module vout_margin_slew_droop_regs_tb_top
    import vout_margin_pkg::*;
;
    typedef struct packed {
        logic [7:0]  pg;
        logic [7:0]  cmd;
        logic [15:0] dat;
    } row_t;
    logic                             clk_sys, rst_n, wr_strobe, rd_strobe, commit_settings;
    logic                             rd_valid_q, cmd_nack_q, wr_refused_q, ok, nk, rf, tmo;
    logic [CMD_W-1:0]                 page, cmd_code, wp_setting;
    logic [DATA_W-1:0]                wr_data, rd_data_q, rdat;
    logic [NUM_PAGES-1:0][1:0]        op_sel;
    logic [NUM_PAGES-1:0][DATA_W-1:0] vout_nominal, vout_min, vout_max, vout_target_q;
    logic [NUM_PAGES-1:0][DATA_W-1:0] slew_applied_q, droop_applied_q;
    logic [NUM_PAGES-1:0]             margin_active_q;
    int                               error_cnt = 0;
    int                               check_count = 0;
    // ordinary writes, one per code and page, each read back afterwards
    row_t rows [8] = '{'{8'h00, 8'h25, 16'h0700}, '{8'h01, 8'h25, 16'h0500},
                       '{8'h00, 8'h26, 16'h0200}, '{8'h01, 8'h26, 16'h0300},
                       '{8'h00, 8'h27, 16'h00c8}, '{8'h01, 8'h27, 16'h0032},
                       '{8'h00, 8'h28, 16'h0100}, '{8'h01, 8'h28, 16'h0700}};
    vout_margin_slew_droop_regs u_vout_margin_slew_droop_regs (.clk_sys(clk_sys),
        .rst_n(rst_n), .page(page), .cmd_code(cmd_code), .wr_strobe(wr_strobe),
        .wr_data(wr_data), .rd_strobe(rd_strobe), .wp_setting(wp_setting),
        .commit_settings(commit_settings), .op_sel(op_sel), .vout_nominal(vout_nominal),
        .vout_min(vout_min), .vout_max(vout_max), .rd_data_q(rd_data_q),
        .rd_valid_q(rd_valid_q), .cmd_nack_q(cmd_nack_q), .wr_refused_q(wr_refused_q),
        .slew_applied_q(slew_applied_q), .droop_applied_q(droop_applied_q),
        .vout_target_q(vout_target_q), .margin_active_q(margin_active_q));
    host_bus_model u_host_bus_model (.clk_sys(clk_sys), .page(page), .cmd_code(cmd_code),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe),
        .wp_setting(wp_setting), .commit_settings(commit_settings), .rd_data_q(rd_data_q),
        .rd_valid_q(rd_valid_q), .cmd_nack_q(cmd_nack_q), .wr_refused_q(wr_refused_q));
    ////////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // verdict in one place, reached by the main sequence or a stalled read
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] rst_val(input logic [7:0] c);
        case (c)
            CMD_MARGIN_HIGH: return RST_MARGIN_HIGH;
            CMD_MARGIN_LOW:  return RST_MARGIN_LOW;
            CMD_SLEW:        return RST_SLEW;
            default:         return RST_DROOP;
        endcase
    endfunction
    // a refused read leaves the read word as it was, so exp is the last good word
    task automatic rd_chk(input logic [7:0] pg, input logic [7:0] cmd, input logic [15:0] exp,
                          input logic good);
        u_host_bus_model.rd(pg, cmd, rdat, ok, nk, tmo);
        if (tmo) begin
            error_cnt++;
            $display("Error read answer expected within 4 cycles seen none");
            results();
        end
        chk("read data", exp, rdat);
        chk("read valid", 16'(good), 16'(ok));
        chk("read nack", 16'(!good), 16'(nk));
    endtask
    task automatic wr_chk(input logic [7:0] pg, input logic [7:0] cmd, input logic [15:0] d,
                          input logic [7:0] wp, input logic exp_rf, input logic exp_nk);
        u_host_bus_model.wr(pg, cmd, d, wp, rf, nk);
        chk("write refused", 16'(exp_rf), 16'(rf));
        chk("write nack", 16'(exp_nk), 16'(nk));
    endtask
    task automatic tgt_chk(input logic [1:0] s0, input logic [1:0] s1, input logic [15:0] t0,
                           input logic [15:0] t1, input logic [1:0] act);
        op_sel = {s1, s0};
        repeat (2) @(negedge clk_sys);
        chk("target page0", t0, vout_target_q[0]);
        chk("target page1", t1, vout_target_q[1]);
        chk("margin active", 16'(act), 16'(margin_active_q));
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence: reset, table rows, then the awkward cases
    initial begin
        rst_n = 1'b0;
        op_sel = '0;
        vout_nominal = {2{16'h0384}};
        vout_min = {2{16'h0100}};
        vout_max = {2{16'h0600}};
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd_chk(rows[i].pg, rows[i].cmd, rst_val(rows[i].cmd), 1'b1);
        end
        chk("slew applied", RST_SLEW, slew_applied_q[1]);
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            wr_chk(rows[i].pg, rows[i].cmd, rows[i].dat, WP_NONE, 1'b0, 1'b0);
            rd_chk(rows[i].pg, rows[i].cmd, rows[i].dat, 1'b1);
        end
        $display("test table done");
        // pending words must not reach the applied copies before the commit
        chk("slew before commit", RST_SLEW, slew_applied_q[0]);
        chk("droop before commit", RST_DROOP, droop_applied_q[1]);
        u_host_bus_model.commit();
        chk("slew page0", 16'h00c8, slew_applied_q[0]);
        chk("slew page1", 16'h0032, slew_applied_q[1]);
        chk("droop page0", 16'h0100, droop_applied_q[0]);
        chk("droop page1", DROOP_MAX, droop_applied_q[1]);
        $display("test commit done");
        tgt_chk(2'h2, 2'h1, 16'h0600, 16'h0300, 2'b11);
        vout_min[0] = 16'h0250;
        tgt_chk(2'h1, 2'h2, 16'h0250, 16'h0500, 2'b11);
        tgt_chk(2'h0, 2'h3, 16'h0384, 16'h0384, 2'b00);
        $display("test target done");
        wr_chk(8'h00, CMD_MARGIN_HIGH, 16'h1234, WP_CTRL_ONLY, 1'b1, 1'b0);
        wr_chk(8'h00, CMD_MARGIN_HIGH, 16'h1234, WP_CTRL_VOUT, 1'b1, 1'b0);
        rd_chk(8'h00, CMD_MARGIN_HIGH, 16'h0700, 1'b1);
        wr_chk(8'h00, 8'h29, 16'h1234, WP_NONE, 1'b0, 1'b1);
        rd_chk(8'h02, CMD_MARGIN_HIGH, 16'h0700, 1'b0);
        wr_chk(PAGE_ALL, CMD_MARGIN_LOW, 16'h0123, WP_NONE, 1'b0, 1'b0);
        rd_chk(8'h01, CMD_MARGIN_LOW, 16'h0123, 1'b1);
        rd_chk(PAGE_ALL, CMD_MARGIN_LOW, 16'h0123, 1'b1);
        $display("test refusals done");
        // widen page 0 window so both margin words pass unclamped
        vout_min[0] = 16'h0100;
        vout_max[0] = 16'h0800;
        tgt_chk(2'h2, 2'h0, 16'h0700, 16'h0384, 2'b01);
        tgt_chk(2'h1, 2'h0, 16'h0123, 16'h0384, 2'b01);
        wr_chk(8'h01, CMD_DROOP, 16'h0200, WP_NONE, 1'b0, 1'b0);
        chk("droop before second commit", DROOP_MAX, droop_applied_q[1]);
        u_host_bus_model.commit();
        chk("droop page1 in span", 16'h0200, droop_applied_q[1]);
        $display("test window and recommit done");
        rst_n = 1'b0;
        @(negedge clk_sys);
        rst_n = 1'b1;
        chk("slew after reset", RST_SLEW, slew_applied_q[0]);
        rd_chk(8'h01, CMD_MARGIN_HIGH, RST_MARGIN_HIGH, 1'b1);
        $display("test second reset done");
        results();
    end
endmodule
`default_nettype wire
